// ### inc/ptei_consts.svh
// Register offsets, field positions and reset values of the task and event interface.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PTEI_CONSTS_SVH
`define PTEI_CONSTS_SVH

`define PTEI_BLOCK_BYTES     32'h0000_1000
`define PTEI_PERIPH_BASE     32'h4000_0000
`define PTEI_ID_LSB          12
`define PTEI_ID_BITS         5
`define PTEI_OFS_BITS        12
`define PTEI_TASK_BASE       12'h000
`define PTEI_EVENT_BASE      12'h100
`define PTEI_SHORT_OFS       12'h200
`define PTEI_INTERRUPT_ENABLE_MASK_OFS       12'h300
`define PTEI_INTERRUPT_ENABLE_SET_ALIAS_OFS    12'h304
`define PTEI_INTERRUPT_ENABLE_CLEAR_ALIAS_OFS    12'h308
`define PTEI_ENABLE_OFS      12'h500
`define PTEI_IDREG_OFS       12'h504
`define PTEI_RESET_WORD      32'h0000_0000
`define PTEI_RESP_OKAY       2'h0
`define PTEI_RESP_SLVERR     2'h2

`endif

// ### inc/ptei_pkg.sv
// Types shared by the task and event interface and its event-record memory.
// Assumes the constants header sits on the include path.
`include "ptei_consts.svh"

package ptei_pkg;

   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } ptei_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } ptei_axi_rsp_t;

   typedef enum logic [2:0] {
      PTEI_IDLE  = 3'b001,
      PTEI_WRESP = 3'b010,
      PTEI_RDATA = 3'b100
   } ptei_phase_t;

endpackage : ptei_pkg

// ### verif/ptei_func_model.sv
// Function logic stand-in: answers task pulse i with event (i+2) mod 4.
// Assumes four tasks and events; DLY sets how slowly it answers.
`timescale 1ns/1ps
`default_nettype none

module ptei_func_model #(
   parameter int DLY = 3
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [3:0] taskOut,
   output logic [3:0]      eventIn
);
   logic [3:0] pipe [DLY];
   // Delay line from task to event
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pipe <= '{default: '0};
      end else begin
         pipe[0] <= taskOut;
         for (int i = 1; i < DLY; i++) pipe[i] <= pipe[i-1];
      end
   end
   assign eventIn = {pipe[DLY-1][1:0], pipe[DLY-1][3:2]};
endmodule // ptei_func_model
`default_nettype wire

// ### verif/ptei_task_event_if_asserts.sv
// Port-level checks of the task and event interface.
// Assumes one clock ref_clk and an active-high asynchronous reset rst.
`timescale 1ns/1ps
`default_nettype none
`include "ptei_consts.svh"

module ptei_tei_asserts
   import ptei_pkg::*;
#(
   parameter int          N_TASKS   = 4,
   parameter int          N_EVENTS  = 4,
   parameter logic [31:0] BASE_ADDR = 32'h4000_0000
) (
   input wire logic                ref_clk,
   input wire logic                rst,
   input wire ptei_axi_req_t       axiReq,
   input wire ptei_axi_rsp_t       axiRsp,
   input wire logic [N_TASKS-1:0]  taskIn,
   input wire logic [N_EVENTS-1:0] eventIn,
   input wire logic [N_TASKS-1:0]  taskOut,
   input wire logic [N_EVENTS-1:0] eventOut,
   input wire logic                enabled,
   input wire logic [4:0]          periphId,
   input wire logic [31:0]         irqLines
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Write of all ones to the enable clear alias
   wire logic clrAll = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
      && axiReq.awaddr == BASE_ADDR + `PTEI_INTERRUPT_ENABLE_CLEAR_ALIAS_OFS && axiReq.wdata == 32'hFFFF_FFFF;
   property p_id; periphId == BASE_ADDR[16:12]; endproperty
   a_id: assert property (p_id) else $error("identifier off base");
   property p_line; (irqLines & ~(32'h0000_0001 << periphId)) == 32'h0000_0000; endproperty
   a_line: assert property (p_line) else $error("foreign irq line");
   property p_ev; eventOut == ($past(eventIn) & {N_EVENTS{$past(enabled)}}); endproperty
   a_ev: assert property (p_ev) else $error("event pulse mismatch");
   property p_off; !enabled |=> taskOut == '0; endproperty
   a_off: assert property (p_off) else $error("task while disabled");
   property p_tin; enabled && |taskIn |=> (taskOut & $past(taskIn)) == $past(taskIn); endproperty
   a_tin: assert property (p_tin) else $error("task input lost");
   property p_drop; clrAll |-> ##[1:4] irqLines == 32'h0000_0000; endproperty
   a_drop: assert property (p_drop) else $error("irq not removed");
   property p_b; axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp);
   endproperty
   a_b: assert property (p_b) else $error("write response dropped");
   property p_r; axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata);
   endproperty
   a_r: assert property (p_r) else $error("read data dropped");
   property p_err; axiReq.arvalid && axiRsp.arready && axiReq.araddr[31:12] != BASE_ADDR[31:12]
      |-> ##[1:2] axiRsp.rvalid && axiRsp.rresp == `PTEI_RESP_SLVERR; endproperty
   a_err: assert property (p_err) else $error("foreign read accepted");
   property p_rst; $fell(rst) |-> irqLines == 32'h0000_0000 && taskOut == '0 && !enabled;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // ptei_tei_asserts
`default_nettype wire

// ### verif/tb_ptei_task_event_if.sv
// Self-checking bench: AXI4-Lite register tests plus task and event lines.
// Assumes the function model answers tasks with events after a delay.
`timescale 1ns/1ps
`default_nettype none
`include "ptei_consts.svh"

module tb_ptei_task_event_if
   import ptei_pkg::*;
;
   localparam logic [31:0] B = 32'h4001_F000;
   logic          ref_clk = 1'b0;
   logic          rst = 1'b1;
   ptei_axi_req_t req = '0;
   ptei_axi_rsp_t rsp;
   logic [3:0]    tbEv = '0, tbTask = '0, modelEv, taskOut, eventOut;
   logic          enabled;
   logic [4:0]    periphId;
   logic [31:0]   irqLines, rd;
   logic [1:0]    rs;
   int            failures = 0, cmp_count = 0, evCnt = 0;
   always #5 ref_clk = ~ref_clk;
   ptei_task_event_if #(.BASE_ADDR(B)) u_dut(.ref_clk(ref_clk), .rst(rst), .axiReq(req),
      .axiRsp(rsp), .taskIn(tbTask), .eventIn(tbEv | modelEv), .taskOut(taskOut),
      .eventOut(eventOut), .enabled(enabled), .periphId(periphId), .irqLines(irqLines));
   ptei_func_model #(.DLY(3)) u_model(.ref_clk(ref_clk), .rst(rst), .taskOut(taskOut),
      .eventIn(modelEv));
   // Count event pulses on line 1
   always @(posedge ref_clk) if (eventOut[1]) evCnt <= evCnt + 1;
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] o, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge ref_clk);
      {req.awaddr, req.awvalid, req.wdata, req.wstrb, req.wvalid, req.bready}
         <= {B + o, 1'b1, d, 4'hF, 1'b1, 1'b1};
      while (!done) begin
         @(posedge ref_clk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
         if (req.bready && rsp.bvalid) begin
            req.bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic rdw(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      {req.araddr, req.arvalid, req.rready} <= {a, 1'b1, 1'b1};
      do begin
         @(posedge ref_clk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (!(req.rready && rsp.rvalid));
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
   endtask
   task automatic rc(input logic [11:0] o, input logic [31:0] e);
      rdw(B + o, rd, rs);
      chk($sformatf("data at %h", o), e, rd);
      chk("response", {30'h0, `PTEI_RESP_OKAY}, {30'h0, rs});
   endtask
   task automatic pulse(input logic [3:0] t, input logic [3:0] e);
      @(posedge ref_clk);
      tbTask <= t;
      tbEv <= e;
      @(posedge ref_clk);
      tbTask <= '0;
      tbEv <= '0;
      repeat (12) @(posedge ref_clk);
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      rc(12'h300, '0);
      rc(12'h200, '0);
      rc(12'h104, '0);
      chk("periphId", 32'd31, {27'h0, periphId});
      rc(12'h504, 32'd31);
      rdw(32'h4000_0000, rd, rs);
      chk("foreign response", {30'h0, `PTEI_RESP_SLVERR}, {30'h0, rs});
      chk("foreign data", '0, rd);
      wr(12'hFFC, 32'hFFFF_FFFF);
      rc(12'hFFC, '0);
      pulse(4'h2, 4'h2);
      rc(12'h104, '0);
      rc(12'h10C, '0);
      wr(12'h200, 32'h1);
      rc(12'h200, 32'h1);
      wr(12'h500, 32'h1);
      rc(12'h500, 32'h1);
      pulse(4'h0, 4'h2);
      pulse(4'h0, 4'h2);
      chk("event pulses", 32'd2, evCnt);
      rc(12'h104, 32'h1);
      rc(12'h104, 32'h1);
      wr(12'h304, 32'h2);
      rc(12'h300, 32'h2);
      rc(12'h308, 32'h2);
      chk("irqLines", 32'h8000_0000, irqLines);
      wr(12'h308, 32'h0);
      rc(12'h304, 32'h2);
      wr(12'h104, 32'h0);
      rc(12'h104, '0);
      chk("irqLines", '0, irqLines);
      pulse(4'h0, 4'h2);
      chk("irqLines", 32'h8000_0000, irqLines);
      wr(12'h308, 32'hFFFF_FFFF);
      rc(12'h300, '0);
      chk("irqLines", '0, irqLines);
      wr(12'h004, 32'h1);
      repeat (12) @(posedge ref_clk);
      rc(12'h10C, 32'h1);
      pulse(4'h4, 4'h0);
      rc(12'h100, 32'h1);
      rc(12'h108, 32'h1);
      tally_and_finish();
   end
endmodule // tb_ptei_task_event_if

bind ptei_task_event_if ptei_tei_asserts #(.N_TASKS(N_TASKS), .N_EVENTS(N_EVENTS),
   .BASE_ADDR(BASE_ADDR)) u_chk(.ref_clk(ref_clk), .rst(rst), .axiReq(axiReq),
   .axiRsp(axiRsp), .taskIn(taskIn), .eventIn(eventIn), .taskOut(taskOut),
   .eventOut(eventOut), .enabled(enabled), .periphId(periphId), .irqLines(irqLines));
`default_nettype wire

// ### verilog/ptei_bit_bank.sv
// Register bank of single-bit flags, one per word, with per-bit write and set.
// Assumes one clock; set pulses and writes arrive in that clock's domain.
`timescale 1ns/1ps
`default_nettype none

module ptei_bit_bank
   import ptei_pkg::*;
#(
   parameter int N = 8
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic [N-1:0] setPulse,
   input  wire logic         wrEn,
   input  wire logic [$clog2(N)-1:0] wrIdx,
   input  wire logic         wrBit,
   input  wire logic [$clog2(N)-1:0] rdIdx,
   output logic [N-1:0]      flags,
   output logic              rdBit
);

   initial begin
      if (N < 2 || N > 32) begin
         $error("ptei_bit_bank: N must be 2..32");
      end
   end

   typedef struct packed {
      logic [N-1:0] flags;
      logic         rdBit;
   } ptei_bank_t;

   ptei_bank_t st;
   ptei_bank_t next_st;

   // Write first, then a same-cycle set overrides the clear
   always_comb begin
      next_st = st;
      if (wrEn) begin
         next_st.flags[wrIdx] = wrBit;
      end
      next_st.flags = next_st.flags | setPulse;
      next_st.rdBit = st.flags[rdIdx];
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign flags = st.flags;
   assign rdBit = st.rdBit;

endmodule // ptei_bit_bank

`default_nettype wire

// ### verilog/ptei_task_event_if.sv
// Generic peripheral task/event/shortcut/interrupt interface on AXI4-Lite.
// Assumes one clock; task and event lines are pulses from logic on ref_clk.
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ptei_consts.svh"

module ptei_task_event_if
   import ptei_pkg::*;
#(
   parameter int          N_TASKS  = 4,
   parameter int          N_EVENTS = 4,
   parameter int          N_SHORTS = 4,
   parameter logic [31:0] BASE_ADDR = 32'h4000_0000,
   // Fixed shortcut wiring: event index in low byte, task index in next byte
   parameter logic [31:0] SHORT_MAP [N_SHORTS] = '{32'h0000_0000, 32'h0000_0101,
                                                    32'h0000_0202, 32'h0000_0303}
) (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire ptei_axi_req_t       axiReq,
   output ptei_axi_rsp_t            axiRsp,
   input  wire logic [N_TASKS-1:0]  taskIn,
   input  wire logic [N_EVENTS-1:0] eventIn,
   output logic [N_TASKS-1:0]       taskOut,
   output logic [N_EVENTS-1:0]      eventOut,
   output logic                     enabled,
   output logic [4:0]               periphId,
   output logic [31:0]              irqLines
);

   localparam int TW = $clog2(N_TASKS);
   localparam int EW = $clog2(N_EVENTS);

   // Elaboration checks
   initial begin
      if (N_SHORTS < 1 || N_SHORTS > 32) begin
         $error("ptei_task_event_if: N_SHORTS must be 1..32");
      end
      if (N_TASKS < 2 || N_TASKS > 64 || N_EVENTS < 2 || N_EVENTS > 32) begin
         $error("ptei_task_event_if: bad task or event count");
      end
      if (BASE_ADDR[`PTEI_ID_LSB-1:0] != '0) begin
         $error("ptei_task_event_if: base not block aligned");
      end
   end

   // Block offset of a byte address
   function automatic logic [11:0] blockOfs(input logic [31:0] a);
      return a[`PTEI_OFS_BITS-1:0];
   endfunction

   // Address falls inside this peripheral's block
   function automatic logic inBlock(input logic [31:0] a);
      return a[31:`PTEI_ID_LSB] == BASE_ADDR[31:`PTEI_ID_LSB];
   endfunction

   typedef struct packed {
      ptei_phase_t       wPh;
      ptei_phase_t       rPh;
      logic              awHeld;
      logic              wHeld;
      logic [31:0]       awAddr;
      logic [31:0]       wData;
      logic [1:0]        bResp;
      logic [31:0]       rData;
      logic [1:0]        rResp;
      logic              rdEvt;
      logic              enable;
      logic [31:0]       interrupt_enable_mask;
      logic [31:0]       shortEn;
      logic [N_TASKS-1:0]  taskPulse;
      logic [N_EVENTS-1:0] evtPulse;
      logic              irq;
   } ptei_state_t;

   ptei_state_t st;
   ptei_state_t next_st;

   logic [N_EVENTS-1:0] evtFlags;
   logic                evtRdBit;
   logic                bankWr;
   logic [EW-1:0]       bankWrIdx;
   logic [EW-1:0]       bankRdIdx;
   logic [N_EVENTS-1:0] evtGated;
   logic [N_TASKS-1:0]  shortTasks;
   logic [11:0]         wOfs;
   logic [11:0]         rOfs;
   logic                doWrite;
   logic [N_EVENTS-1:0] ienMask;

   assign periphId = BASE_ADDR[`PTEI_ID_LSB +: `PTEI_ID_BITS];

   assign evtGated = st.enable ? eventIn : '0;

   always_comb begin
      shortTasks = '0;
      for (int s = 0; s < N_SHORTS; s++) begin
         if (st.shortEn[s] && evtGated[SHORT_MAP[s][EW-1:0]]) begin
            shortTasks[SHORT_MAP[s][8 +: TW]] = 1'b1;
         end
      end
   end

   assign wOfs      = blockOfs(st.awHeld ? st.awAddr : axiReq.awaddr);
   assign rOfs      = blockOfs(axiReq.araddr);
   assign doWrite   = st.wPh == PTEI_IDLE
                      && (st.awHeld || axiReq.awvalid) && (st.wHeld || axiReq.wvalid);
   assign bankWrIdx = wOfs[2 +: EW];
   assign bankRdIdx = rOfs[2 +: EW];
   // event write of zero or one stores the bit
   assign bankWr    = doWrite && inBlock(st.awHeld ? st.awAddr : axiReq.awaddr)
                      && wOfs >= `PTEI_EVENT_BASE && wOfs < `PTEI_EVENT_BASE + 12'(4*N_EVENTS);
   assign ienMask   = st.interrupt_enable_mask[N_EVENTS-1:0];

   ptei_bit_bank #(
      .N (N_EVENTS)
   ) u_evt_bank (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .setPulse (evtGated),
      .wrEn     (bankWr),
      .wrIdx    (bankWrIdx),
      .wrBit    ((st.wHeld ? st.wData[0] : axiReq.wdata[0])),
      .rdIdx    (bankRdIdx),
      .flags    (evtFlags),
      .rdBit    (evtRdBit)
   );

   // Bus slave, register effects and pulse generation
   always_comb begin
      logic [31:0] wd;
      logic [31:0] wa;
      logic        hit;
      logic [N_TASKS-1:0] swTask;
      wd     = st.wHeld ? st.wData : axiReq.wdata;
      wa     = st.awHeld ? st.awAddr : axiReq.awaddr;
      hit    = inBlock(wa);
      swTask = '0;
      next_st = st;
      next_st.taskPulse = '0;
      // event pulses pass regardless of record
      next_st.evtPulse  = evtGated;
      // Capture address and data in either order
      if (st.wPh == PTEI_IDLE && axiReq.awvalid && !st.awHeld) begin
         next_st.awHeld = 1'b1;
         next_st.awAddr = axiReq.awaddr;
      end
      if (st.wPh == PTEI_IDLE && axiReq.wvalid && !st.wHeld) begin
         next_st.wHeld = 1'b1;
         next_st.wData = axiReq.wdata;
      end
      if (doWrite) begin
         next_st.awHeld = 1'b0;
         next_st.wHeld  = 1'b0;
         next_st.wPh    = PTEI_WRESP;
         next_st.bResp  = `PTEI_RESP_OKAY;
         if (!hit) begin
            next_st.bResp = `PTEI_RESP_SLVERR;
         end else if (wOfs < `PTEI_TASK_BASE + 12'(4*N_TASKS)) begin
            swTask[wOfs[2 +: TW]] = wd[0];
         end else if (wOfs == `PTEI_SHORT_OFS) begin
            next_st.shortEn = wd & ((N_SHORTS == 32) ? 32'hFFFF_FFFF
                              : ((32'h0000_0001 << N_SHORTS) - 32'h0000_0001));
         end else if (wOfs == `PTEI_INTERRUPT_ENABLE_MASK_OFS) begin
            // main word, then set, then clear
            next_st.interrupt_enable_mask = wd & 32'((64'h1 << N_EVENTS) - 64'h1);
         end else if (wOfs == `PTEI_INTERRUPT_ENABLE_SET_ALIAS_OFS) begin
            next_st.interrupt_enable_mask = st.interrupt_enable_mask | (wd & 32'((64'h1 << N_EVENTS) - 64'h1));
         end else if (wOfs == `PTEI_INTERRUPT_ENABLE_CLEAR_ALIAS_OFS) begin
            next_st.interrupt_enable_mask = st.interrupt_enable_mask & ~wd;
         end else if (wOfs == `PTEI_ENABLE_OFS) begin
            next_st.enable = wd[0];
         end
      end
      if (st.wPh == PTEI_WRESP && axiReq.bready) begin
         next_st.wPh = PTEI_IDLE;
      end
      if (st.enable) begin
         next_st.taskPulse = swTask | taskIn | shortTasks;
      end
      // Read channel
      next_st.rdEvt = 1'b0;
      if (st.rPh == PTEI_IDLE && axiReq.arvalid) begin
         next_st.rPh   = PTEI_RDATA;
         next_st.rData = `PTEI_RESET_WORD;
         next_st.rResp = `PTEI_RESP_OKAY;
         if (!inBlock(axiReq.araddr)) begin
            next_st.rResp = `PTEI_RESP_SLVERR;
         end else if (rOfs >= `PTEI_EVENT_BASE
                      && rOfs < `PTEI_EVENT_BASE + 12'(4*N_EVENTS)) begin
            next_st.rdEvt = 1'b1;
         end else if (rOfs == `PTEI_SHORT_OFS) begin
            next_st.rData = st.shortEn;
         end else if (rOfs == `PTEI_INTERRUPT_ENABLE_MASK_OFS || rOfs == `PTEI_INTERRUPT_ENABLE_SET_ALIAS_OFS
                      || rOfs == `PTEI_INTERRUPT_ENABLE_CLEAR_ALIAS_OFS) begin
            next_st.rData = st.interrupt_enable_mask;
         end else if (rOfs == `PTEI_ENABLE_OFS) begin
            next_st.rData = {31'h0, st.enable};
         end else if (rOfs == `PTEI_IDREG_OFS) begin
            next_st.rData = {27'h0, periphId};
         end
      end
      // Event bit arrives one cycle after the address
      if (st.rdEvt) begin
         next_st.rData = {31'h0, evtRdBit};
      end
      if (st.rPh == PTEI_RDATA && !st.rdEvt && axiReq.rready) begin
         next_st.rPh = PTEI_IDLE;
      end
      // any enabled event set asserts interrupt
      next_st.irq = |(evtFlags & ienMask);
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         // zero reset of events and enables
         st       <= '0;
         st.wPh   <= PTEI_IDLE;
         st.rPh   <= PTEI_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // Handshake outputs
   always_comb begin
      axiRsp         = '0;
      axiRsp.awready = st.wPh == PTEI_IDLE && !st.awHeld;
      axiRsp.wready  = st.wPh == PTEI_IDLE && !st.wHeld;
      axiRsp.bvalid  = st.wPh == PTEI_WRESP;
      axiRsp.bresp   = st.bResp;
      axiRsp.arready = st.rPh == PTEI_IDLE;
      axiRsp.rvalid  = st.rPh == PTEI_RDATA && !st.rdEvt;
      axiRsp.rdata   = st.rData;
      axiRsp.rresp   = st.rResp;
   end

   assign taskOut  = st.taskPulse;
   assign eventOut = st.evtPulse;
   assign enabled  = st.enable;

   always_comb begin
      irqLines = '0;
      irqLines[periphId] = st.irq;
   end

endmodule // ptei_task_event_if

`default_nettype wire
